// ### phase_timer.sv
// down counter that marks the end of a timed phase
// loaded by the controller on the same clock
`timescale 1ns/1ps
module phase_timer #(
	parameter int W = 4
) (
	input  wire logic         mclk,
	input  wire logic         rstn,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              done
);
	logic [W-1:0] remain;
	// done ignores load so a caller may reload on done without a loop
	assign done = (remain == '0);
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			remain <= '0;
		else if (load)
			remain <= count;
		else if (remain != '0)
			remain <= remain - 1'b1;
	end
endmodule // phase_timer

// ### sram_ctl.sv
// host controller for a 128K x 8 asynchronous sram, clocked by mclk
// assumes the memory floats and returns its outputs within one mclk period
`timescale 1ns/1ps
`include "sram_ctl_defines.svh"
module sram_ctl #(
	parameter int AW = 17,
	parameter int DW = 8
) (
	input  wire logic          mclk,
	input  wire logic          rstn,
	input  wire logic          req,
	input  wire logic          req_write,
	input  wire logic [AW-1:0] req_addr,
	input  wire logic [DW-1:0] req_wdata,
	output logic               busy,
	output logic               rd_valid,
	output logic [DW-1:0]      rd_data,
	output logic [AW-1:0]      sram_addr,
	output logic               chip_select_active_low,
	output logic               chip_select_active_high,
	output logic               write_strobe_n,
	output logic               output_drive_enable_n,
	input  wire logic [DW-1:0] data_in,
	output logic [DW-1:0]      data_out,
	output logic               data_oe
);
	localparam logic [3:0] PULSE_CNT = 4'(`WRITE_PULSE_CYC);
	localparam logic [3:0] RWAIT_CNT = 4'(`READ_CYCLE_CYC);
	localparam logic [3:0] FLOAT_CNT = 4'(`FLOAT_CYC);

	sram_ctl_pkg::state_t state;
	sram_ctl_pkg::state_t next_state;
	logic [DW-1:0] din_meta;
	logic [DW-1:0] din_sync;
	logic          tload;
	logic [3:0]    tcount;
	logic          tdone;

	phase_timer #(.W(4)) u_timer (
		.mclk  (mclk),
		.rstn  (rstn),
		.load  (tload),
		.count (tcount),
		.done  (tdone)
	);

	wire take     = (state == sram_ctl_pkg::st_idle) && req;
	wire go_write = take && req_write;
	wire go_read  = take && !req_write;

	always_comb begin
		next_state = state;
		tload = 1'b0;
		tcount = 4'h0;
		case (state)
			sram_ctl_pkg::st_idle: begin
				if (go_write)
					next_state = sram_ctl_pkg::st_wsetup;
				else if (go_read) begin
					next_state = sram_ctl_pkg::st_rwait;
					tload = 1'b1;
					tcount = RWAIT_CNT;
				end
			end
			// address, selects and data settle a full cycle before strobe falls
			sram_ctl_pkg::st_wsetup: begin
				next_state = sram_ctl_pkg::st_wpulse;
				tload = 1'b1;
				tcount = PULSE_CNT;
			end
			// pulse length comes from the timer, one cycle covers the minimum
			sram_ctl_pkg::st_wpulse: begin
				if (tdone)
					next_state = sram_ctl_pkg::st_wend;
			end
			// strobe high; address and data still held one cycle
			sram_ctl_pkg::st_wend: begin
				next_state = sram_ctl_pkg::st_idle;
			end
			// float phase is loaded on the cycle the wait runs out
			sram_ctl_pkg::st_rwait: begin
				if (tdone) begin
					next_state = sram_ctl_pkg::st_rfloat;
					tload = 1'b1;
					tcount = FLOAT_CNT;
				end
			end
			// output enable high; wait for memory release before idle
			sram_ctl_pkg::st_rfloat: begin
				if (tdone)
					next_state = sram_ctl_pkg::st_idle;
			end
			default: next_state = sram_ctl_pkg::st_idle;
		endcase
	end

	wire in_write = (next_state == sram_ctl_pkg::st_wsetup) || (next_state == sram_ctl_pkg::st_wpulse)
		|| (next_state == sram_ctl_pkg::st_wend);
	wire in_read  = (next_state == sram_ctl_pkg::st_rwait);
	wire sel_next = in_write || in_read || (next_state == sram_ctl_pkg::st_rfloat);
	wire rd_done  = (state == sram_ctl_pkg::st_rwait) && tdone;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			state <= sram_ctl_pkg::st_idle;
		else
			state <= next_state;
	end

	// data pins come from outside; two flops before use
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			din_meta <= `DATA_RESET;
			din_sync <= `DATA_RESET;
		end else begin
			din_meta <= data_in;
			din_sync <= din_meta;
		end
	end

	// address and write data latched only when a request is taken
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sram_addr <= `ADDR_RESET;
			data_out  <= `DATA_RESET;
		end else if (take) begin
			sram_addr <= req_addr;
			data_out  <= req_wdata;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			chip_select_active_low  <= 1'b1;
			chip_select_active_high <= 1'b0;
			write_strobe_n          <= 1'b1;
			output_drive_enable_n   <= 1'b1;
			data_oe                 <= 1'b0;
			busy                    <= 1'b0;
		end else begin
			chip_select_active_low  <= !sel_next;
			chip_select_active_high <= sel_next;
			write_strobe_n          <= !(next_state == sram_ctl_pkg::st_wpulse);
			output_drive_enable_n   <= !in_read;
			// drive from setup through end, while output enable is held high
			data_oe                 <= in_write;
			busy                    <= (next_state != sram_ctl_pkg::st_idle);
		end
	end

	// sample two cycles late to cover the synchroniser
	logic [1:0] rd_pipe;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rd_pipe  <= 2'b00;
			rd_valid <= 1'b0;
			rd_data  <= `DATA_RESET;
		end else begin
			rd_pipe  <= {rd_pipe[0], rd_done};
			rd_valid <= rd_pipe[1];
			if (rd_pipe[1])
				rd_data <= din_sync;
		end
	end


	// pin-level checks on what this controller drives
	a_strobe_read_high: assert property (@(posedge mclk) disable iff (!rstn)
		!output_drive_enable_n |-> write_strobe_n) else $error("strobe low during read");
	a_read_select_low: assert property (@(posedge mclk) disable iff (!rstn)
		!output_drive_enable_n |-> !chip_select_active_low) else $error("select high in read");
	a_strobe_no_read: assert property (@(posedge mclk) disable iff (!rstn)
		!write_strobe_n |-> output_drive_enable_n) else $error("output enable low in write");
	a_select_busy: assert property (@(posedge mclk) disable iff (!rstn)
		!chip_select_active_low |-> busy) else $error("selected while idle");
	// no pin left active once the controller is back at idle
	a_idle_pins: assert property (@(posedge mclk) disable iff (!rstn)
		!busy |-> chip_select_active_low && !chip_select_active_high && write_strobe_n && output_drive_enable_n
		&& !data_oe) else $error("pins active at idle");
	// strobe low for the whole pulse phase, then released
	sequence s_pulse;
		!write_strobe_n ##1 write_strobe_n;
	endsequence
	// selects and drive kept on the edge the strobe rises, active-low select and drive dropped on the next
	sequence s_write_hold;
		!chip_select_active_low && chip_select_active_high && data_oe
		##1 chip_select_active_low && !data_oe;
	endsequence
	a_pulse_width: assert property (@(posedge mclk) disable iff (!rstn)
		$fell(write_strobe_n) |=> s_pulse) else $error("short write pulse");
	a_cs_before_end: assert property (@(posedge mclk) disable iff (!rstn)
		$fell(write_strobe_n) |-> !$past(chip_select_active_low) && $past(chip_select_active_high))
		else $error("select late");
	a_addr_stable: assert property (@(posedge mclk) disable iff (!rstn)
		!write_strobe_n |-> $stable(sram_addr)) else $error("address moved in write");
	// address may not move while a select is held from the cycle before
	a_addr_in_select: assert property (@(posedge mclk) disable iff (!rstn)
		!chip_select_active_low && !$past(chip_select_active_low) |-> $stable(sram_addr)) else $error("address moved");
	a_addr_hold: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(write_strobe_n) |-> $stable(sram_addr) && data_oe) else $error("hold lost");
	a_end_hold: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(write_strobe_n) |-> s_write_hold) else $error("write end order");
	a_data_setup: assert property (@(posedge mclk) disable iff (!rstn)
		$fell(write_strobe_n) |-> $past(data_oe) && $stable(data_out)) else $error("data late");
	a_no_contend: assert property (@(posedge mclk) disable iff (!rstn)
		data_oe |-> output_drive_enable_n) else $error("bus contention");
	// wait, then two synchroniser stages during the float, before the answer is seen
	a_read_answer: assert property (@(posedge mclk) disable iff (!rstn)
		(take && !req_write) |-> ##5 rd_valid) else $error("read answer late");
endmodule // sram_ctl

// ### sram_ctl_defines.svh
// timing constants and reset values for the async sram host controller
// assumes a 50 MHz mclk; times in ns, counts derived by round-up
`ifndef SRAM_CTL_DEFINES_SVH
`define SRAM_CTL_DEFINES_SVH
`define CLK_PERIOD_NS        20
`define WRITE_CYCLE_PERIOD_NS 12
`define WRITE_PULSE_WIDTH_NS  8
`define CS_TO_WRITE_END_NS    10
`define ADDR_TO_WRITE_END_NS  10
`define DATA_SETUP_TO_WRITE_END_NS 7
`define READ_CYCLE_NS        12
`define OUTPUT_FLOAT_NS      5
`define OUTPUT_RETURN_AFTER_WRITE_NS 3
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYC  `CEIL_CYC(`WRITE_PULSE_WIDTH_NS)
`define WRITE_CYCLE_CYC  `CEIL_CYC(`WRITE_CYCLE_PERIOD_NS)
`define READ_CYCLE_CYC   `CEIL_CYC(`READ_CYCLE_NS)
`define FLOAT_CYC        `CEIL_CYC(`OUTPUT_FLOAT_NS)
`define ADDR_RESET       17'h00000
`define DATA_RESET       8'h00
`endif

// ### sram_ctl_pkg.sv
// types for the async sram host controller
// used by the controller; its timing counter does not use it
package sram_ctl_pkg;
	typedef enum logic [5:0] {
		st_idle   = 6'b000001,
		st_wsetup = 6'b000010,
		st_wpulse = 6'b000100,
		st_wend   = 6'b001000,
		st_rfloat = 6'b010000,
		st_rwait  = 6'b100000
	} state_t;
endpackage

// ### sram_ctl_tb.sv
// self-checking bench for sram_ctl against a reference byte map
// assumes sram_mem_model as the memory on the pins
`timescale 1ns/1ps
module sram_ctl_tb;
	logic        mclk, rstn, req, req_write, busy, rd_valid, data_oe;
	logic        chip_select_active_low, chip_select_active_high, write_strobe_n, output_drive_enable_n;
	logic [16:0] req_addr, sram_addr, a;
	logic [7:0]  req_wdata, rd_data, data_in, data_out;
	logic [31:0] r;
	logic [16:0] addrs [$];
	logic [7:0]  ref_mem [int];
	int          failures, compares, cycles;

	sram_ctl u_sram_ctl (.mclk(mclk), .rstn(rstn), .req(req), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data), .sram_addr(sram_addr),
		.chip_select_active_low(chip_select_active_low), .chip_select_active_high(chip_select_active_high),
		.write_strobe_n(write_strobe_n), .output_drive_enable_n(output_drive_enable_n),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe));
	sram_mem_model #(.ACC_NS(9)) u_sram_mem_model (.sram_addr(sram_addr),
		.chip_select_active_low(chip_select_active_low), .chip_select_active_high(chip_select_active_high),
		.write_strobe_n(write_strobe_n), .output_drive_enable_n(output_drive_enable_n),
		.data_out(data_out), .data_oe(data_oe), .data_in(data_in));

	task chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			failures++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task test_done;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one transfer; poke repeats req while busy with another address
	task op(input logic w, input logic [16:0] ad, input logic [7:0] d, input logic poke);
		int n;
		@(negedge mclk);
		req = 1'b1; req_write = w; req_addr = ad; req_wdata = d;
		@(negedge mclk);
		req = poke; req_addr = ~ad; req_wdata = ~d;
		if (!w) chk(write_strobe_n === 1'b1 && output_drive_enable_n === 1'b0 && chip_select_active_low === 1'b0
			&& sram_addr === ad, "read pins");
		@(negedge mclk);
		req = 1'b0;
		if (w) chk(write_strobe_n === 1'b0 && chip_select_active_low === 1'b0 && chip_select_active_high === 1'b1
			&& sram_addr === ad && data_out === d && data_oe === 1'b1, "write pins");
		if (w) ref_mem[ad] = d;
		for (n = 0; n < 8 && (w ? busy !== 1'b0 : rd_valid !== 1'b1); n++) @(negedge mclk);
		if (w) chk(busy === 1'b0 && data_oe === 1'b0, "write end");
		else chk(rd_valid === 1'b1 && rd_data === ref_mem[ad], "read data");
	endtask

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			$display("[FAIL] %0t timeout", $time);
			test_done;
		end
	end

	initial begin
		rstn = 1'b0; req = 1'b0; req_write = 1'b0; req_addr = 17'h00000; req_wdata = 8'h00;
		r = $urandom(32'h9367BDC6);
		repeat (12) @(negedge mclk);
		rstn = 1'b1;
		chk(chip_select_active_low === 1'b1 && chip_select_active_high === 1'b0 && write_strobe_n === 1'b1
			&& output_drive_enable_n === 1'b1 && data_oe === 1'b0 && busy === 1'b0, "idle pins");
		op(1'b1, 17'h00000, 8'hA5, 1'b0);
		op(1'b1, 17'h1FFFF, 8'h5A, 1'b0);
		op(1'b0, 17'h00000, 8'h00, 1'b0);
		op(1'b0, 17'h1FFFF, 8'h00, 1'b0);
		$display("boundary test done");
		for (int i = 0; i < 24; i++) begin
			r = $urandom;
			a = r[16:0];
			addrs.push_back(a);
			op(1'b1, a, r[24:17], 1'b0);
		end
		foreach (addrs[i]) op(1'b0, addrs[i], 8'h00, 1'b0);
		$display("random test done");
		op(1'b1, 17'h10F0F, 8'hC3, 1'b0);
		op(1'b1, 17'h0F0F0, 8'h96, 1'b1);
		op(1'b0, 17'h10F0F, 8'h00, 1'b1);
		op(1'b0, 17'h0F0F0, 8'h00, 1'b0);
		$display("busy refusal test done");
		@(negedge mclk);
		rstn = 1'b0;
		repeat (2) @(negedge mclk);
		chk(busy === 1'b0 && rd_valid === 1'b0 && sram_addr === 17'h00000 && data_oe === 1'b0, "reset pins");
		rstn = 1'b1;
		op(1'b0, 17'h1FFFF, 8'h00, 1'b0);
		$display("reset test done");
		test_done;
	end
endmodule // sram_ctl_tb

// ### sram_mem_model.sv
// behavioural 128K x 8 async memory at the far side of sram_ctl
// assumes the controller's pins; resolves the data wire for data_in
`timescale 1ns/1ps
module sram_mem_model #(
	parameter int ACC_NS = 3
) (
	input  wire logic [16:0] sram_addr,
	input  wire logic        chip_select_active_low,
	input  wire logic        chip_select_active_high,
	input  wire logic        write_strobe_n,
	input  wire logic        output_drive_enable_n,
	input  wire logic [7:0]  data_out,
	input  wire logic        data_oe,
	output logic [7:0]       data_in
);
	logic [7:0] mem [0:131071];
	logic [7:0] held = 8'h00;
	wire sel = !chip_select_active_low && chip_select_active_high;
	wire wr_act = sel && !write_strobe_n;
	wire rd_req = sel && write_strobe_n && !output_drive_enable_n;
	wire #(ACC_NS) rd_dly = rd_req;
	wire rd_drv = rd_req && rd_dly;
	// undriven wire shows the inverse of the last word
	assign data_in = data_oe ? data_out : rd_drv ? mem[sram_addr] : ~held;
	always @(negedge wr_act) mem[sram_addr] = data_in;
	always @(negedge rd_drv) held = mem[sram_addr];
endmodule // sram_mem_model
